/* verilog/hsdc_pkg.sv */
// Purpose: constants for the two-channel high-side driver control block
// Assumes: one 8-bit register port, 100 MHz clock
// Notes: offsets other than the data register are chosen locally
package hsdc_pkg;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_FLAG = 4'h2;
  localparam logic [3:0] ADDR_IEN = 4'h3;
  localparam logic [3:0] ADDR_ICLR = 4'h4;
  // control register fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_OCME_BIT = 4;
  localparam int CTRL_IE_BIT = 7;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // over-current mask interval
  localparam int MASK_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MASK_CYCLES = MASK_TIME_NS / CLK_PERIOD_NS;
  // settling wait that software keeps after enabling, in clock cycles
  localparam int SETTLE_CYCLES = 10;
endpackage

/* verilog/hsdc_top.sv */
// Purpose: driver control, over-current shutdown and interrupt
// Assumes: source and stop inputs already synchronous; i_oc is synchronised here
// Notes: register reads answer one cycle after the read strobe
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module hsdc_top #(
  parameter int MASK_CYCLES = hsdc_pkg::MASK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // system mode and routed sources
  input wire logic i_stop,
  input wire logic [1:0] i_src,
  // analog side
  input wire logic [1:0] i_oc,
  output logic [1:0] o_drv_on,
  output logic [1:0] o_ol_en,
  // interrupt
  output logic o_irq
);
  logic [1:0] data_ff;
  logic [1:0] en_ff;
  logic ocme_ff;
  logic ocie_ff;
  logic [1:0] flag_ff;
  logic [1:0] ien_ff;
  logic [1:0] oc_s1_ff;
  logic [1:0] oc_s2_ff;
  logic stop_ff;
  logic [1:0] req_q_ff;
  logic [7:0] rdata_ff;
  logic [1:0] masked;
  logic [1:0] req;
  logic [1:0] oc_hit;
  logic [1:0] clr;
  logic [31:0] mcnt_ff [2];
  logic wr_data;
  logic wr_ctrl;
  logic wr_ien;
  logic wr_clr;
  logic stop_entry;

  // write decode, one strobe per register
  assign wr_data = i_wr && (i_addr == hsdc_pkg::ADDR_DATA);
  assign wr_ctrl = i_wr && (i_addr == hsdc_pkg::ADDR_CTRL);
  assign wr_ien = i_wr && (i_addr == hsdc_pkg::ADDR_IEN);
  // the flag register itself also takes write-one clears
  assign wr_clr = i_wr && (i_addr == hsdc_pkg::ADDR_ICLR || i_addr == hsdc_pkg::ADDR_FLAG);
  // stop entry is the first cycle with the stop level high
  assign stop_entry = i_stop && !stop_ff;

  // requested state per channel: data bit or routed source
  assign req = (en_ff & i_src) | (~en_ff & data_ff);
  assign clr = wr_clr ? i_wdata[1:0] : 2'h0;

  assign o_drv_on = req & ~flag_ff;
  assign o_ol_en = en_ff & ~req;

  // over-current pins cross from the analog domain
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      oc_s1_ff <= 2'h0;
      oc_s2_ff <= 2'h0;
    end
    else
    begin
      oc_s1_ff <= i_oc;
      oc_s2_ff <= oc_s1_ff;
    end
  end

  // previous stop level, for the entry edge
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      stop_ff <= 1'b0;
    else
      stop_ff <= i_stop;
  end

  // previous requested state, for the switch-on edge
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      req_q_ff <= 2'h0;
    else
      req_q_ff <= req;
  end

  // mask counters restart on each switch-on edge
  for (genvar g = 0; g < 2; g++)
  begin : g_mask
    always_ff @(posedge i_mclk)
    begin
      if (i_rst)
        mcnt_ff[g] <= 32'h0;
      else if (req[g] && !req_q_ff[g])
        mcnt_ff[g] <= 32'(MASK_CYCLES);
      else if (mcnt_ff[g] != 32'h0)
        mcnt_ff[g] <= mcnt_ff[g] - 32'h1;
    end
    assign masked[g] = ocme_ff && (mcnt_ff[g] != 32'h0 || (req[g] && !req_q_ff[g]));
  end

  assign oc_hit = oc_s2_ff & ~masked;

  // data register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      data_ff <= hsdc_pkg::DATA_RST[1:0];
    else if (stop_entry)
      data_ff <= 2'h0;
    else if (wr_data)
      data_ff <= i_wdata[1:0];
  end

  // enable bits of the control register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      en_ff <= hsdc_pkg::CTRL_RST[1:0];
    else if (wr_ctrl)
      en_ff <= i_wdata[hsdc_pkg::CTRL_EN_LSB +: 2];
  end

  // interrupt enable bit of the control register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      ocie_ff <= hsdc_pkg::CTRL_RST[hsdc_pkg::CTRL_IE_BIT];
    else if (wr_ctrl)
      ocie_ff <= i_wdata[hsdc_pkg::CTRL_IE_BIT];
  end

  // mask enable; changing it under a live driver would cut the blanking short
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      ocme_ff <= hsdc_pkg::CTRL_RST[hsdc_pkg::CTRL_OCME_BIT];
    else if (wr_ctrl && en_ff[0] == 1'b0)
      ocme_ff <= i_wdata[hsdc_pkg::CTRL_OCME_BIT];
  end

  // per-flag interrupt enables
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      ien_ff <= 2'h0;
    else if (wr_ien)
      ien_ff <= i_wdata[1:0];
  end

  // flags: set wins over clear; stop mode does not touch them
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      flag_ff <= 2'h0;
    else
      flag_ff <= (flag_ff & ~clr) | oc_hit;
  end

  assign o_irq = ocie_ff && !i_stop && |(flag_ff & ien_ff);

  // read mux, one cycle latency
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      rdata_ff <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        hsdc_pkg::ADDR_DATA: rdata_ff <= {6'h00, req};
        hsdc_pkg::ADDR_CTRL: rdata_ff <= {ocie_ff, 2'h0, ocme_ff, 2'h0, en_ff};
        hsdc_pkg::ADDR_FLAG: rdata_ff <= {6'h00, flag_ff};
        hsdc_pkg::ADDR_IEN: rdata_ff <= {6'h00, ien_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end
  assign o_rdata = rdata_ff;

  // assertions
  property p_flag_off;
    @(posedge i_mclk) disable iff (i_rst) |flag_ff |-> ((o_drv_on & flag_ff) == 2'h0);
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("driver on with flag set");
  property p_flag_set;
    @(posedge i_mclk) disable iff (i_rst) oc_hit[0] |=> flag_ff[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_stop_clr;
    @(posedge i_mclk) disable iff (i_rst) (i_stop && !stop_ff) |=> data_ff == 2'h0;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop did not clear data");
  property p_irq_run;
    @(posedge i_mclk) disable iff (i_rst) i_stop |-> !o_irq;
  endproperty
  a_irq_run: assert property (p_irq_run) else $error("irq in stop");
  property p_ocme_lock;
    @(posedge i_mclk) disable iff (i_rst) en_ff[0] |=> $stable(ocme_ff);
  endproperty
  a_ocme_lock: assert property (p_ocme_lock) else $error("mask bit changed while enabled");
  property p_read_dis;
    @(posedge i_mclk) disable iff (i_rst) (i_rd && i_addr == hsdc_pkg::ADDR_DATA && !en_ff[0])
      |=> o_rdata[0] == $past(data_ff[0]);
  endproperty
  a_read_dis: assert property (p_read_dis) else $error("wrong data readback");
  property p_zero_keep;
    @(posedge i_mclk) disable iff (i_rst) (flag_ff[0] && clr[0] == 1'b0) |=> flag_ff[0];
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("flag lost");
  property p_ol;
    @(posedge i_mclk) disable iff (i_rst) (o_ol_en & req) == 2'h0;
  endproperty
  a_ol: assert property (p_ol) else $error("open-load while on");

  // steps shared by the multi-cycle properties below
  sequence s_switch_on0;
    req[0] && !req_q_ff[0];
  endsequence
  sequence s_switch_on1;
    req[1] && !req_q_ff[1];
  endsequence
  sequence s_oc_sync0;
    oc_s1_ff[0] ##1 oc_s2_ff[0];
  endsequence
  sequence s_stop_enter;
    i_stop && !stop_ff;
  endsequence

  property p_flag_set1;
    @(posedge i_mclk) disable iff (i_rst) oc_hit[1] |=> flag_ff[1];
  endproperty
  a_flag_set1: assert property (p_flag_set1) else $error("flag one not set");

  property p_unmasked0;
    @(posedge i_mclk) disable iff (i_rst) s_oc_sync0 ##0 !masked[0] |=> flag_ff[0];
  endproperty
  a_unmasked0: assert property (p_unmasked0) else $error("synchronised over-current lost");

  property p_mask_hide0;
    @(posedge i_mclk) disable iff (i_rst) (ocme_ff && !flag_ff[0]) ##0 s_switch_on0 |=> !flag_ff[0];
  endproperty
  a_mask_hide0: assert property (p_mask_hide0) else $error("flag set at masked switch-on");

  property p_mask_hide1;
    @(posedge i_mclk) disable iff (i_rst) (ocme_ff && !flag_ff[1]) ##0 s_switch_on1 |=> !flag_ff[1];
  endproperty
  a_mask_hide1: assert property (p_mask_hide1) else $error("flag one set at masked switch-on");

  property p_mask_hold0;
    @(posedge i_mclk) disable iff (i_rst) (ocme_ff && mcnt_ff[0] != 32'h0 && !flag_ff[0]) |=> !flag_ff[0];
  endproperty
  a_mask_hold0: assert property (p_mask_hold0) else $error("flag set inside mask window");

  property p_mask_len0;
    @(posedge i_mclk) disable iff (i_rst) mcnt_ff[0] <= 32'(MASK_CYCLES);
  endproperty
  a_mask_len0: assert property (p_mask_len0) else $error("mask window too long");

  property p_mask_len1;
    @(posedge i_mclk) disable iff (i_rst) mcnt_ff[1] <= 32'(MASK_CYCLES);
  endproperty
  a_mask_len1: assert property (p_mask_len1) else $error("mask window one too long");

  property p_clear_one0;
    @(posedge i_mclk) disable iff (i_rst) (clr[0] && !oc_hit[0]) |=> !flag_ff[0];
  endproperty
  a_clear_one0: assert property (p_clear_one0) else $error("flag not cleared");

  property p_clear_one1;
    @(posedge i_mclk) disable iff (i_rst) (clr[1] && !oc_hit[1]) |=> !flag_ff[1];
  endproperty
  a_clear_one1: assert property (p_clear_one1) else $error("flag one not cleared");

  property p_zero_keep1;
    @(posedge i_mclk) disable iff (i_rst) (flag_ff[1] && !clr[1]) |=> flag_ff[1];
  endproperty
  a_zero_keep1: assert property (p_zero_keep1) else $error("flag one lost");

  property p_stop_keep;
    @(posedge i_mclk) disable iff (i_rst)
      s_stop_enter ##0 (clr == 2'h0 && oc_hit == 2'h0) |=> flag_ff == $past(flag_ff);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop entry changed flags");

  property p_stop_leave;
    @(posedge i_mclk) disable iff (i_rst)
      (!i_stop && stop_ff && clr == 2'h0 && oc_hit == 2'h0) |=> flag_ff == $past(flag_ff);
  endproperty
  a_stop_leave: assert property (p_stop_leave) else $error("stop exit changed flags");

  property p_irq_on;
    @(posedge i_mclk) disable iff (i_rst) (ocie_ff && !i_stop && (flag_ff & ien_ff) != 2'h0) |-> o_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_irq_off;
    @(posedge i_mclk) disable iff (i_rst) !ocie_ff |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_read_src0;
    @(posedge i_mclk) disable iff (i_rst) (i_rd && i_addr == hsdc_pkg::ADDR_DATA && en_ff[0])
      |=> o_rdata[0] == $past(i_src[0]);
  endproperty
  a_read_src0: assert property (p_read_src0) else $error("wrong source readback");

  property p_read_src1;
    @(posedge i_mclk) disable iff (i_rst) (i_rd && i_addr == hsdc_pkg::ADDR_DATA && en_ff[1])
      |=> o_rdata[1] == $past(i_src[1]);
  endproperty
  a_read_src1: assert property (p_read_src1) else $error("wrong source one readback");

  property p_read_dis1;
    @(posedge i_mclk) disable iff (i_rst) (i_rd && i_addr == hsdc_pkg::ADDR_DATA && !en_ff[1])
      |=> o_rdata[1] == $past(data_ff[1]);
  endproperty
  a_read_dis1: assert property (p_read_dis1) else $error("wrong data one readback");

  property p_data_width;
    @(posedge i_mclk) disable iff (i_rst) (i_rd && i_addr == hsdc_pkg::ADDR_DATA) |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_data_width: assert property (p_data_width) else $error("data read beyond bits 1-0");

  property p_back0;
    @(posedge i_mclk) disable iff (i_rst) !flag_ff[0] |-> o_drv_on[0] == req[0];
  endproperty
  a_back0: assert property (p_back0) else $error("control not returned");

  property p_back1;
    @(posedge i_mclk) disable iff (i_rst) !flag_ff[1] |-> o_drv_on[1] == req[1];
  endproperty
  a_back1: assert property (p_back1) else $error("control one not returned");
endmodule

/* tb/hsdc_load.sv */
// Purpose: load model on the two driver outputs
// Assumes: a shorted load trips only while driven
// Notes: the short is commanded by the bench
`timescale 1ns/1ps
module hsdc_load (
  // driver side
  input wire logic [1:0] i_drv_on,
  input wire logic [1:0] i_short,
  // detect side
  output logic [1:0] o_oc
);
  // current flows only while the switch is on
  assign o_oc = i_drv_on & i_short;
endmodule

/* tb/hsdc_top_bench.sv */
// Purpose: self-checking bench for the driver control block
// Assumes: mask interval shortened to 5 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
`define CHK(n, e, s) total_checks++; if ((s) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end
module hsdc_top_bench;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_stop = 1'b0;
  logic [1:0] i_src = 2'h0;
  logic [1:0] sh = 2'h0;
  logic [1:0] oc;
  logic [7:0] o_rdata;
  logic [1:0] o_drv_on;
  logic [1:0] o_ol_en;
  logic o_irq;
  logic [7:0] d;
  int fail_count = 0;
  int total_checks = 0;
  hsdc_top #(.MASK_CYCLES(5)) uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stop(i_stop), .i_src(i_src), .i_oc(oc),
    .o_drv_on(o_drv_on), .o_ol_en(o_ol_en), .o_irq(o_irq));
  hsdc_load load (.i_drv_on(o_drv_on), .i_short(sh), .o_oc(oc));
  // free-running 100 MHz clock
  initial
  begin
    forever #5 i_mclk = ~i_mclk;
  end
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
    @(posedge i_mclk);
  endtask
  task automatic t_plain();
    wr(hsdc_pkg::ADDR_DATA, 8'h03);
    rd(hsdc_pkg::ADDR_DATA);
    `CHK("data", 8'h03, d)
    `CHK("drv", 2'h3, o_drv_on)
    rd(4'hf);
    `CHK("unmapped", 8'h00, d)
    wr(hsdc_pkg::ADDR_DATA, 8'h00);
  endtask
  task automatic t_src();
    wr(hsdc_pkg::ADDR_CTRL, 8'h81);
    repeat (hsdc_pkg::SETTLE_CYCLES) @(posedge i_mclk);
    rd(hsdc_pkg::ADDR_DATA);
    `CHK("src off", 1'b0, d[0])
    `CHK("ol", 2'h1, o_ol_en)
    wr(hsdc_pkg::ADDR_CTRL, 8'h91);
    rd(hsdc_pkg::ADDR_CTRL);
    `CHK("mask", 1'b0, d[4])
    i_src <= 2'h1;
    rd(hsdc_pkg::ADDR_DATA);
    `CHK("src on", 1'b1, d[0])
    `CHK("ol on", 2'h0, o_ol_en)
  endtask
  task automatic t_fault();
    wr(hsdc_pkg::ADDR_IEN, 8'h01);
    wr(hsdc_pkg::ADDR_DATA, 8'h02);
    sh <= 2'h1;
    repeat (5) @(posedge i_mclk);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("flag", 8'h01, d)
    `CHK("off", 2'h2, o_drv_on)
    `CHK("irq", 1'b1, o_irq)
    i_stop <= 1'b1;
    rd(hsdc_pkg::ADDR_DATA);
    `CHK("stop clr", 1'b0, d[1])
    `CHK("irq stop", 1'b0, o_irq)
    i_stop <= 1'b0;
    wr(hsdc_pkg::ADDR_ICLR, 8'h00);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("kept", 8'h01, d)
    sh <= 2'h0;
    wr(hsdc_pkg::ADDR_ICLR, 8'h01);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("cleared", 8'h00, d)
    `CHK("back", 2'h1, o_drv_on)
  endtask
  task automatic t_mask();
    wr(hsdc_pkg::ADDR_CTRL, 8'h80);
    wr(hsdc_pkg::ADDR_CTRL, 8'h90);
    sh <= 2'h1;
    wr(hsdc_pkg::ADDR_CTRL, 8'h91);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("masked", 8'h00, d)
    `CHK("on in mask", 2'h1, o_drv_on)
    repeat (8) @(posedge i_mclk);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("unmasked", 8'h01, d)
    rd(hsdc_pkg::ADDR_CTRL);
    `CHK("mask set", 1'b1, d[4])
    sh <= 2'h0;
    wr(hsdc_pkg::ADDR_FLAG, 8'h01);
    rd(hsdc_pkg::ADDR_FLAG);
    `CHK("flag clr", 8'h00, d)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence after a four-cycle reset
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_plain();
    t_src();
    t_fault();
    t_mask();
    report_and_stop();
  end
  // hang guard, far beyond the roughly ninety cycles needed
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
